// ==== rtl/decode_map.svh ====
// Purpose: Constants for the instruction decode and timing block
// Assumes: 14-bit instruction words, four oscillator cycles per instruction
// Notes: Field positions are bit positions in the word; opcode patterns are bit values
`ifndef DECODE_MAP_SVH
`define DECODE_MAP_SVH

`define INSTR_W 14
`define PROG_COUNTER_W 15
`define PHASES_PER_INSTR 4
`define PHASE_FIRST 2'h0
`define PHASE_READ 2'h1
`define PHASE_STORE 2'h2
`define PHASE_LAST 2'h3

`define OPC_MSB 13
`define OPC_LSB 8
`define DEST_BIT 7
`define FILE_MSB 6
`define BITPOS_MSB 9
`define BITPOS_LSB 7
`define ADDR11_MSB 10
`define LIT8_MSB 7
`define PTR_BIT 2
`define STEP_MSB 1
`define FILE_RESET 7'h00

`define INDIRECT_PORT0 7'h00
`define INDIRECT_PORT1 7'h01

`define OP_CALL_HI 3'h4
`define OP_GOTO_HI 3'h5
`define OP_RETURN 14'h0008
`define OP_RETFIE 14'h0009
`define OP_CALLW 14'h000a
`define OP_BRW 14'h000b
`define OP_PTRSTEP_HI 10'h001
`define OP_RETLW 6'h34
`define OP_BRA_HI 5'h19
`define OP_DECFSZ 6'h0b
`define OP_INCFSZ 6'h0f
`define OP_CLR 6'h01
`define OP_BCF 4'h4
`define OP_BSF 4'h5
`define OP_BTFSC 4'h6
`define OP_BTFSS 4'h7
`define OP_ASRF 6'h37
`define OP_LSLF 6'h35
`define OP_LSRF 6'h36
`define OP_SUBWFB 6'h3b
`define OP_ADDWFC 6'h3d

`endif

// ==== rtl/decode_pkg.sv ====
// Purpose: Types shared by the instruction decode and timing block
// Assumes: Constants come from decode_map.svh
// Notes: The decoded word travels as one packed struct
package decode_pkg;

    typedef enum logic [1:0] {
        CLASS_BYTE,
        CLASS_BIT,
        CLASS_LITCTL
    } instr_class_t;

    typedef enum logic [3:0] {
        KIND_PLAIN,
        KIND_CALL,
        KIND_GOTO,
        KIND_CALLW,
        KIND_RETURN,
        KIND_RETLW,
        KIND_RETFIE,
        KIND_BRA,
        KIND_BRW,
        KIND_SKIP,
        KIND_PTRSTEP
    } op_kind_t;

    typedef enum logic [1:0] {
        STEP_PRE_INC,
        STEP_PRE_DEC,
        STEP_POST_INC,
        STEP_POST_DEC
    } auto_step_kind_t;

    typedef enum logic [1:0] {
        ST_EXEC,
        ST_EXTRA,
        ST_FLUSH
    } exec_state_t;

    typedef struct packed {
        logic valid;
        instr_class_t iclass;
        op_kind_t kind;
        logic [5:0] opcode;
        logic dest_file;
        logic [6:0] file_addr;
        logic [2:0] bit_pos;
        logic [7:0] lit8;
        logic [10:0] addr11;
        logic ptr_sel;
        auto_step_kind_t auto_step_kind;
        logic uses_file;
        logic writes_file;
        logic writes_acc;
    } decoded_t;

endpackage

// ==== rtl/phase_gen.sv ====
// Purpose: Oscillator phase counter splitting each instruction cycle
// Assumes: One instruction cycle per four oscillator clocks
// Notes: Phase output is a register
`timescale 1ns/100ps
`include "decode_map.svh"

module phase_gen (
    input wire logic clock,
    input wire logic arst_n,
    output logic [1:0] phase_r
);
    logic [1:0] phase_nxt;

    always_comb begin
        // Wraps from the last phase back to the first after four clocks
        phase_nxt = 2'(phase_r + 2'h1); // [RULE7]
    end

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            phase_r <= `PHASE_FIRST;
        end else begin
            phase_r <= phase_nxt;
        end
    end

    default clocking cb @(posedge clock); endclocking
    default disable iff (!arst_n);

    a_phase_wrap: assert property ( // [RULE7]
        (phase_r == `PHASE_LAST) |=> (phase_r == `PHASE_FIRST)
    ) else $error("phase did not wrap after the last phase");

endmodule

// ==== rtl/cpu_decode_timing.sv ====
// Purpose: Decode 14-bit instruction words and pace their execution
// Assumes: Program memory presents the next word by the last phase
// Notes: Datapath supplies skip results and return or relative targets
//
// Notes on behaviour
// [RULE1] Each instruction is one 14-bit word
// [RULE2] Three classes: byte, bit, literal/control
// [RULE3] One cycle default; both calls take two
// [RULE4] All three return forms take two cycles
// [RULE5] Jumps, branches and taken skips take two
// [RULE6] Indirect reference into program memory adds one
// [RULE7] Instruction cycle is four oscillator clocks
// [RULE8] File operands are read, modified, then stored
// [RULE9] Register location is seven bits, 0x00-0x7F
// [RULE10] Target bit: 0 accumulator, 1 file
// [RULE11] Bit position is three bits
// [RULE12] Pointer select picks pair 0 or 1
// [RULE13] Auto-step picks pre/post increment/decrement
// [RULE14] Ignored encoding bits never change behaviour
// [RULE15] Immediate is data or address per opcode
// [RULE16] Byte ops: opcode 13:8, target 7, location 6:0
// [RULE17] Call/jump carry 11 bits; literals 8 bits
// [RULE18] Redirect loads counter and discards fetched word
`timescale 1ns/100ps
`include "decode_map.svh"

module cpu_decode_timing (
    input wire logic clock,
    input wire logic arst_n,
    input wire logic [13:0] instr_word,
    input wire logic skip_taken,
    input wire logic pointer_in_progmem,
    input wire logic [14:0] branch_target,
    output decode_pkg::decoded_t decoded_r,
    output logic [1:0] q_phase,
    output logic cycle_start_r,
    output logic [14:0] program_counter_r,
    output logic flush_fetch_r,
    output logic file_read_r,
    output logic file_write_r,
    output logic acc_write_r,
    output logic extra_cycle_r
);
    decode_pkg::exec_state_t state_r, state_nxt;
    decode_pkg::decoded_t fresh, decoded_nxt;
    logic [14:0] program_counter_nxt;
    logic cycle_start_nxt, flush_fetch_nxt, file_read_nxt;
    logic file_write_nxt, acc_write_nxt, extra_cycle_nxt;
    logic boundary, need_extra, redirect, jump_abs;

    phase_gen u_phase (
        .clock(clock),
        .arst_n(arst_n),
        .phase_r(q_phase)
    );

    assign boundary = (q_phase == `PHASE_LAST); // [RULE7]

    // Field split of the incoming word
    always_comb begin
        fresh = '0;
        fresh.valid = 1'b1;
        fresh.opcode = instr_word[`OPC_MSB:`OPC_LSB]; // [RULE1] [RULE16]
        fresh.dest_file = instr_word[`DEST_BIT]; // [RULE16]
        fresh.file_addr = instr_word[`FILE_MSB:0]; // [RULE9] [RULE16]
        fresh.bit_pos = instr_word[`BITPOS_MSB:`BITPOS_LSB]; // [RULE11]
        fresh.lit8 = instr_word[`LIT8_MSB:0]; // [RULE15] [RULE17]
        fresh.addr11 = instr_word[`ADDR11_MSB:0]; // [RULE15] [RULE17]
        fresh.ptr_sel = instr_word[`PTR_BIT]; // [RULE12]
        fresh.auto_step_kind =
            decode_pkg::auto_step_kind_t'(instr_word[`STEP_MSB:0]); // [RULE13]
        fresh.iclass = decode_pkg::CLASS_LITCTL;
        fresh.kind = decode_pkg::KIND_PLAIN;
        // Only the significant bits are compared; don't-care bits fall out
        if (instr_word[13:12] == 2'h1) begin // [RULE2]
            fresh.iclass = decode_pkg::CLASS_BIT;
            fresh.uses_file = 1'b1; // [RULE8]
            if (instr_word[13:10] == `OP_BTFSC ||
                    instr_word[13:10] == `OP_BTFSS) begin
                fresh.kind = decode_pkg::KIND_SKIP; // [RULE5]
            end else begin
                fresh.writes_file = 1'b1; // [RULE8]
            end
        end else if (instr_word[13:11] == `OP_CALL_HI) begin
            fresh.kind = decode_pkg::KIND_CALL; // [RULE3]
        end else if (instr_word[13:11] == `OP_GOTO_HI) begin
            fresh.kind = decode_pkg::KIND_GOTO; // [RULE5]
        end else if (instr_word == `OP_RETURN) begin
            fresh.kind = decode_pkg::KIND_RETURN; // [RULE4]
        end else if (instr_word == `OP_RETFIE) begin
            fresh.kind = decode_pkg::KIND_RETFIE; // [RULE4]
        end else if (instr_word == `OP_CALLW) begin
            fresh.kind = decode_pkg::KIND_CALLW; // [RULE3]
        end else if (instr_word == `OP_BRW) begin
            fresh.kind = decode_pkg::KIND_BRW; // [RULE5]
        end else if (instr_word[13:4] == `OP_PTRSTEP_HI) begin
            fresh.kind = decode_pkg::KIND_PTRSTEP; // [RULE13]
        end else if (instr_word[13:8] == `OP_RETLW) begin
            fresh.kind = decode_pkg::KIND_RETLW; // [RULE4]
            fresh.writes_acc = 1'b1;
        end else if (instr_word[13:9] == `OP_BRA_HI) begin
            fresh.kind = decode_pkg::KIND_BRA; // [RULE5]
        end else if ((instr_word[13:12] == 2'h0 &&
                    !(instr_word[13:8] == 6'h00 && !instr_word[7])) ||
                instr_word[13:8] == `OP_ASRF ||
                instr_word[13:8] == `OP_LSLF ||
                instr_word[13:8] == `OP_LSRF ||
                instr_word[13:8] == `OP_SUBWFB ||
                instr_word[13:8] == `OP_ADDWFC) begin
            fresh.iclass = decode_pkg::CLASS_BYTE; // [RULE2]
            fresh.uses_file = 1'b1; // [RULE8]
            fresh.writes_file = instr_word[`DEST_BIT]; // [RULE10]
            fresh.writes_acc = !instr_word[`DEST_BIT]; // [RULE10]
            // Clearing the accumulator names no register; low bits ignored
            if (instr_word[13:8] == `OP_CLR && !instr_word[`DEST_BIT]) begin
                fresh.uses_file = 1'b0; // [RULE14]
                fresh.file_addr = `FILE_RESET; // [RULE14]
            end
            if (instr_word[13:8] == `OP_DECFSZ ||
                    instr_word[13:8] == `OP_INCFSZ) begin
                fresh.kind = decode_pkg::KIND_SKIP; // [RULE5]
            end
        end else begin
            fresh.writes_acc = 1'b1;
        end
        if (fresh.iclass == decode_pkg::CLASS_LITCTL) begin
            fresh.dest_file = 1'b0;
            fresh.file_addr = `FILE_RESET; // [RULE14]
        end
    end

    // Timing: extra cycle first, then the discard cycle of a redirect
    always_comb begin
        need_extra = decoded_r.valid && decoded_r.uses_file &&
            (decoded_r.file_addr == `INDIRECT_PORT0 ||
            decoded_r.file_addr == `INDIRECT_PORT1) &&
            pointer_in_progmem; // [RULE6]
        jump_abs = (decoded_r.kind == decode_pkg::KIND_CALL) ||
            (decoded_r.kind == decode_pkg::KIND_GOTO);
        redirect = decoded_r.valid &&
            (decoded_r.kind != decode_pkg::KIND_PLAIN) &&
            (decoded_r.kind != decode_pkg::KIND_PTRSTEP) &&
            (decoded_r.kind != decode_pkg::KIND_SKIP ||
            skip_taken); // [RULE3] [RULE4] [RULE5]
        state_nxt = state_r;
        decoded_nxt = decoded_r;
        program_counter_nxt = program_counter_r;
        extra_cycle_nxt = extra_cycle_r;
        if (boundary) begin
            extra_cycle_nxt = 1'b0;
            case (state_r)
                decode_pkg::ST_EXEC: begin
                    if (need_extra) begin
                        state_nxt = decode_pkg::ST_EXTRA; // [RULE6]
                        extra_cycle_nxt = 1'b1;
                    end else if (redirect) begin
                        state_nxt = decode_pkg::ST_FLUSH; // [RULE18]
                        decoded_nxt = '0;
                    end else begin
                        decoded_nxt = fresh;
                    end
                end
                decode_pkg::ST_EXTRA: begin
                    if (redirect) begin
                        state_nxt = decode_pkg::ST_FLUSH; // [RULE18]
                        decoded_nxt = '0;
                    end else begin
                        state_nxt = decode_pkg::ST_EXEC;
                        decoded_nxt = fresh;
                    end
                end
                default: begin
                    state_nxt = decode_pkg::ST_EXEC;
                    decoded_nxt = fresh;
                end
            endcase
            // A taken skip keeps counting; the skipped word is dropped
            if (state_nxt == decode_pkg::ST_FLUSH &&
                    decoded_r.kind != decode_pkg::KIND_SKIP) begin
                program_counter_nxt = jump_abs ?
                    {program_counter_r[14:11], decoded_r.addr11} :
                    branch_target; // [RULE17] [RULE18]
            end else if (state_nxt != decode_pkg::ST_EXTRA) begin
                program_counter_nxt = 15'(program_counter_r + 15'h1);
            end
        end
    end

    // Strobes: read in the second phase, store in the last
    always_comb begin
        cycle_start_nxt = boundary;
        flush_fetch_nxt = boundary && (state_nxt == decode_pkg::ST_FLUSH);
        file_read_nxt = (q_phase == `PHASE_FIRST) &&
            (state_r == decode_pkg::ST_EXEC) &&
            decoded_r.valid && decoded_r.uses_file; // [RULE8]
        file_write_nxt = (q_phase == `PHASE_STORE) &&
            (state_r == decode_pkg::ST_EXEC) &&
            decoded_r.valid && decoded_r.writes_file; // [RULE8] [RULE10]
        acc_write_nxt = (q_phase == `PHASE_STORE) &&
            (state_r == decode_pkg::ST_EXEC) &&
            decoded_r.valid && decoded_r.writes_acc; // [RULE10]
    end

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            state_r <= decode_pkg::ST_FLUSH;
            decoded_r <= '0;
            program_counter_r <= '0;
            cycle_start_r <= 1'b0;
            flush_fetch_r <= 1'b0;
            file_read_r <= 1'b0;
            file_write_r <= 1'b0;
            acc_write_r <= 1'b0;
            extra_cycle_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            decoded_r <= decoded_nxt;
            program_counter_r <= program_counter_nxt;
            cycle_start_r <= cycle_start_nxt;
            flush_fetch_r <= flush_fetch_nxt;
            file_read_r <= file_read_nxt;
            file_write_r <= file_write_nxt;
            acc_write_r <= acc_write_nxt;
            extra_cycle_r <= extra_cycle_nxt;
        end
    end

    default clocking cb @(posedge clock); endclocking
    default disable iff (!arst_n);

    a_cycle_four_clocks: assert property ( // [RULE7]
        cycle_start_r |=> (!cycle_start_r) [*3] ##1 cycle_start_r
    ) else $error("instruction cycle is not four clocks");

    a_call_two_cycles: assert property ( // [RULE3]
        (boundary && state_r == decode_pkg::ST_EXEC && !need_extra &&
        decoded_r.valid && (decoded_r.kind == decode_pkg::KIND_CALL ||
        decoded_r.kind == decode_pkg::KIND_CALLW))
        |=> (state_r == decode_pkg::ST_FLUSH) ##4
        (state_r == decode_pkg::ST_EXEC)
    ) else $error("call did not take two cycles");

    a_return_two_cycles: assert property ( // [RULE4]
        (boundary && state_r == decode_pkg::ST_EXEC && !need_extra &&
        decoded_r.valid && (decoded_r.kind == decode_pkg::KIND_RETURN ||
        decoded_r.kind == decode_pkg::KIND_RETLW ||
        decoded_r.kind == decode_pkg::KIND_RETFIE))
        |=> flush_fetch_r && !decoded_r.valid
    ) else $error("return did not take two cycles");

    a_branch_flush: assert property ( // [RULE5]
        (boundary && state_r == decode_pkg::ST_EXEC && !need_extra &&
        decoded_r.valid && decoded_r.kind == decode_pkg::KIND_SKIP &&
        skip_taken) |=> (state_r == decode_pkg::ST_FLUSH) [*4]
    ) else $error("taken skip did not hold a discard cycle");

    a_plain_one_cycle: assert property ( // [RULE3]
        (boundary && state_r == decode_pkg::ST_EXEC && !need_extra &&
        decoded_r.kind == decode_pkg::KIND_PLAIN)
        |=> state_r == decode_pkg::ST_EXEC && !flush_fetch_r
    ) else $error("plain instruction took more than one cycle");

    a_extra_cycle: assert property ( // [RULE6]
        (boundary && state_r == decode_pkg::ST_EXEC && need_extra)
        |=> extra_cycle_r [*4] ##1 !extra_cycle_r
    ) else $error("indirect program memory access lacks extra cycle");

    a_rmw_read_first: assert property ( // [RULE8]
        $rose(file_write_r) |-> $past(file_read_r, 2)
    ) else $error("file register stored without prior read");

    a_dest_acc_only: assert property ( // [RULE10]
        acc_write_r && decoded_r.iclass == decode_pkg::CLASS_BYTE
        |-> !decoded_r.dest_file && !file_write_r
    ) else $error("target bit steered result wrongly");

    a_jump_target: assert property ( // [RULE18]
        (boundary && state_r == decode_pkg::ST_EXEC && !need_extra &&
        decoded_r.valid && decoded_r.kind == decode_pkg::KIND_GOTO)
        |=> program_counter_r[10:0] == $past(decoded_r.addr11)
    ) else $error("jump did not load its target");

    a_skip_one_cycle: assert property ( // [RULE5]
        (boundary && state_r == decode_pkg::ST_EXEC && !need_extra &&
        decoded_r.valid && decoded_r.kind == decode_pkg::KIND_SKIP &&
        !skip_taken) |=> state_r == decode_pkg::ST_EXEC && !flush_fetch_r
    ) else $error("skip not taken still held a discard cycle");

    // The added cycle only stalls; a second store would corrupt the file
    a_extra_quiet: assert property ( // [RULE6]
        extra_cycle_r |-> !file_read_r && !file_write_r && !acc_write_r
    ) else $error("strobe raised during the added indirect cycle");

    a_fetch_step: assert property ( // [RULE3]
        (boundary && state_r == decode_pkg::ST_EXEC && !need_extra &&
        !redirect)
        |=> program_counter_r == $past(program_counter_r) + 15'h1
    ) else $error("fetch address did not step after one cycle");

    c_call_seen: cover property (
        flush_fetch_r && $past(decoded_r.kind, 1) == decode_pkg::KIND_CALL
    );
    c_extra_seen: cover property ($rose(extra_cycle_r));
    c_skip_taken: cover property (
        decoded_r.kind == decode_pkg::KIND_SKIP && boundary && skip_taken
    );
    c_return_seen: cover property (
        flush_fetch_r && $past(decoded_r.kind) == decode_pkg::KIND_RETURN
    );

endmodule

// ==== tb/prog_mem.sv ====
// Purpose: Program memory model feeding words to the decode block
// Assumes: Word follows the fetch address with no wait
// Notes: Unwritten words hold a pattern that must never execute
`timescale 1ns/100ps

module prog_mem (
    input wire logic [14:0] program_counter,
    output logic [13:0] instr_word
);
    logic [13:0] mem_r [512];

    initial begin
        for (int i = 0; i < 512; i++) begin
            mem_r[i] = 14'h3fff;
        end
    end

    // Whole word per address, never split across fetches
    assign instr_word = mem_r[program_counter[8:0]];

    task automatic put(input int a, input logic [13:0] w);
        mem_r[a] = w;
    endtask
endmodule

// ==== tb/cpu_instruction_decode_timing_bench.sv ====
// Purpose: Self-checking bench for the decode and timing block
// Assumes: Inputs change on the falling edge, outputs sampled there
// Notes: One program runs straight through; each task checks a stretch
`timescale 1ns/100ps

`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin \
    error_cnt++; $display("CHECK FAILED t=%0t got=%h exp=%h", \
    $time, (a), (b)); end end

module cpu_instruction_decode_timing_bench;
    logic clock = 1'b0;
    logic arst_n = 1'b0;
    logic skip_taken = 1'b0;
    logic pointer_in_progmem = 1'b0;
    logic [14:0] branch_target = 15'h0000;
    logic [13:0] instr_word;
    decode_pkg::decoded_t decoded_r;
    logic [1:0] q_phase;
    logic cycle_start_r, flush_fetch_r, file_read_r, file_write_r;
    logic acc_write_r, extra_cycle_r;
    logic [14:0] program_counter_r;
    int error_cnt = 0;
    int check_count = 0;
    decode_pkg::decoded_t d;
    logic [4:0] st;
    logic [14:0] fetch_addr;
    int n;
    logic [13:0] rw [6] = '{14'h0008, 14'h34a5, 14'h000b,
        14'h000a, 14'h0009, 14'h3205};
    decode_pkg::op_kind_t rk [6] = '{decode_pkg::KIND_RETURN,
        decode_pkg::KIND_RETLW, decode_pkg::KIND_BRW,
        decode_pkg::KIND_CALLW, decode_pkg::KIND_RETFIE,
        decode_pkg::KIND_BRA};
    int ra [7] = '{36, 64, 80, 96, 112, 120, 256};

    always #5 clock = ~clock;

    cpu_decode_timing DUT (
        .clock(clock),
        .arst_n(arst_n),
        .instr_word(instr_word),
        .skip_taken(skip_taken),
        .pointer_in_progmem(pointer_in_progmem),
        .branch_target(branch_target),
        .decoded_r(decoded_r),
        .q_phase(q_phase),
        .cycle_start_r(cycle_start_r),
        .program_counter_r(program_counter_r),
        .flush_fetch_r(flush_fetch_r),
        .file_read_r(file_read_r),
        .file_write_r(file_write_r),
        .acc_write_r(acc_write_r),
        .extra_cycle_r(extra_cycle_r)
    );

    prog_mem mem (
        .program_counter(program_counter_r),
        .instr_word(instr_word)
    );

    task end_sim;
        $display("Checks %0d, mismatches %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    // Runs one instruction cycle group; st = {rd, wr, acc, flush, extra}
    // Strobes count only in their own phase, so a late one shows as lost
    task step;
        d = decoded_r;
        fetch_addr = program_counter_r;
        st = 5'h00;
        n = 0;
        do begin
            `CHK(q_phase, n[1:0])
            st[4] |= file_read_r & (q_phase == 2'h1);
            st[3] |= file_write_r & (q_phase == 2'h3);
            st[2] |= acc_write_r & (q_phase == 2'h3);
            st[1] |= flush_fetch_r;
            st[0] |= extra_cycle_r;
            n++;
            @(negedge clock);
        end while (!(cycle_start_r && !extra_cycle_r) && n < 40);
    endtask

    task flushed(input logic [14:0] tgt);
        step;
        `CHK(d.valid, 1'b0)
        `CHK(st, 5'b00010)
        `CHK(fetch_addr, tgt)
        `CHK(n, 4)
    endtask

    task t_byte;
        step;
        `CHK(d.valid, 1'b1)
        `CHK(d.iclass, decode_pkg::CLASS_BYTE)
        `CHK(d.opcode, 6'h07)
        `CHK(d.dest_file, 1'b1)
        `CHK(d.file_addr, 7'h55)
        `CHK(st, 5'b11000)
        `CHK(n, 4)
        step;
        `CHK(d.dest_file, 1'b0)
        `CHK(d.file_addr, 7'h2a)
        `CHK(st, 5'b10100)
    endtask

    task t_bit;
        step;
        `CHK(d.iclass, decode_pkg::CLASS_BIT)
        `CHK(d.bit_pos, 3'h6)
        `CHK(d.file_addr, 7'h7f)
        `CHK(st, 5'b11000)
    endtask

    // Clear-accumulator with its ignored low bits set
    task t_ignored;
        step;
        `CHK(d.opcode, 6'h01)
        `CHK(d.uses_file, 1'b0)
        `CHK(d.file_addr, 7'h00)
        `CHK(st, 5'b00100)
    endtask

    task t_jump;
        step;
        `CHK(d.kind, decode_pkg::KIND_GOTO)
        `CHK(d.iclass, decode_pkg::CLASS_LITCTL)
        `CHK(d.addr11, 11'h010)
        `CHK(n, 4)
        flushed(15'h0010);
        step;
        `CHK(d.kind, decode_pkg::KIND_CALL)
        `CHK(d.addr11, 11'h020)
        flushed(15'h0020);
    endtask

    task t_skip;
        skip_taken = 1'b1;
        step;
        skip_taken = 1'b0;
        `CHK(d.kind, decode_pkg::KIND_SKIP)
        `CHK(st, 5'b11000)
        flushed(15'h0022);
        step;
        `CHK(d.kind, decode_pkg::KIND_SKIP)
        `CHK(st, 5'b10100)
        `CHK(n, 4)
    endtask

    // Write-only move still reads its operand
    task t_indirect;
        pointer_in_progmem = 1'b1;
        step;
        pointer_in_progmem = 1'b0;
        `CHK(d.valid, 1'b1)
        `CHK(d.file_addr, 7'h00)
        `CHK(st, 5'b11001)
        `CHK(n, 8)
    endtask

    task t_redirect;
        for (int i = 0; i < 6; i++) begin
            branch_target = 15'(ra[i + 1]);
            step;
            `CHK(d.kind, rk[i])
            `CHK(n, 4)
            `CHK(st, (i == 1) ? 5'b00100 : 5'b00000)
            if (i == 1) begin
                `CHK(d.lit8, 8'ha5)
            end
            flushed(15'(ra[i + 1]));
        end
    endtask

    task t_ptr;
        for (int i = 0; i < 4; i++) begin
            step;
            `CHK(d.kind, decode_pkg::KIND_PTRSTEP)
            `CHK(d.ptr_sel, ~i[0])
            `CHK(d.auto_step_kind,
                decode_pkg::auto_step_kind_t'(i[1:0]))
            `CHK(n, 4)
        end
    endtask

    // Bit tests taken and not, bit clear, clear file, upper-space shift
    task t_bitops;
        skip_taken = 1'b1;
        step;
        skip_taken = 1'b0;
        `CHK(d.kind, decode_pkg::KIND_SKIP)
        `CHK(d.iclass, decode_pkg::CLASS_BIT)
        `CHK(d.bit_pos, 3'h2)
        `CHK(st, 5'b10000)
        flushed(15'h0106);
        step;
        `CHK(d.kind, decode_pkg::KIND_SKIP)
        `CHK(d.file_addr, 7'h7e)
        `CHK(n, 4)
        step;
        `CHK(d.kind, decode_pkg::KIND_PLAIN)
        `CHK(d.bit_pos, 3'h0)
        `CHK(st, 5'b11000)
        step;
        `CHK(d.iclass, decode_pkg::CLASS_BYTE)
        `CHK(d.file_addr, 7'h33)
        `CHK(st, 5'b11000)
        step;
        `CHK(d.opcode, 6'h35)
        `CHK(d.iclass, decode_pkg::CLASS_BYTE)
        `CHK(st, 5'b10100)
    endtask

    initial begin
        #20000;
        error_cnt++;
        end_sim;
    end

    initial begin
        @(negedge clock);
        mem.put(0, 14'h07d5);
        mem.put(1, 14'h072a);
        mem.put(2, 14'h177f);
        mem.put(3, 14'h0103);
        mem.put(4, 14'h2810);
        mem.put(16, 14'h2020);
        mem.put(32, 14'h0b90);
        mem.put(34, 14'h0f11);
        mem.put(35, 14'h0080);
        for (int i = 0; i < 6; i++) begin
            mem.put(ra[i], rw[i]);
        end
        for (int i = 0; i < 4; i++) begin
            mem.put(256 + i, 14'(16 + ((i + 1) % 2) * 4 + i));
        end
        mem.put(260, 14'h1d20);
        mem.put(262, 14'h1bfe);
        mem.put(263, 14'h1040);
        mem.put(264, 14'h01b3);
        mem.put(265, 14'h3512);
        repeat (11) @(negedge clock);
        arst_n = 1'b1;
        for (int i = 0; i < 20 && !cycle_start_r; i++) begin
            @(negedge clock);
        end
        t_byte;
        t_bit;
        t_ignored;
        t_jump;
        t_skip;
        t_indirect;
        t_redirect;
        t_ptr;
        t_bitops;
        end_sim;
    end
endmodule
